// >>> chan_pkg.sv
// Shared constants for the channel protection, inrush and PWM block
package chan_pkg;
  // Bus geometry
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  localparam int          NUM_CH          = 8;
  localparam int          NUM_PAIR        = 4;
  localparam int          CNT_W           = 21;

  // Register byte offsets
  localparam logic [7:0]  OFS_SWITCH      = 8'h00;
  localparam logic [7:0]  OFS_PAIR        = 8'h04;
  localparam logic [7:0]  OFS_OCL         = 8'h08;
  localparam logic [7:0]  OFS_INRUSH      = 8'h0c;
  localparam logic [7:0]  OFS_ERR         = 8'h10;
  localparam logic [7:0]  OFS_TRIM        = 8'h14;
  localparam logic [7:0]  OFS_PWM0        = 8'h18;
  localparam logic [7:0]  OFS_PWM1        = 8'h1c;
  localparam logic [7:0]  OFS_MAP         = 8'h20;
  localparam logic [7:0]  OFS_STATUS      = 8'h24;

  // Field positions
  localparam int          PWM_DUTY_LSB    = 0;
  localparam int          PWM_SEL_LSB     = 8;
  localparam int          MAP1_LSB        = 8;
  localparam int          STAT_LATCH_LSB  = 8;
  localparam int          STAT_AUTO_LSB   = 16;

  // Reset values
  localparam logic [3:0]  TRIM_RESET      = 4'h8;
  localparam logic [7:0]  DUTY_RESET      = 8'h00;
  localparam logic [1:0]  SEL_RESET       = 2'h0;
  localparam logic [7:0]  AUTOCFG_MASK    = 8'hfc;

  // Divider select codes
  localparam logic [1:0]  SEL_DIV1024     = 2'h0;
  localparam logic [1:0]  SEL_DIV512      = 2'h1;
  localparam logic [1:0]  SEL_DIV256      = 2'h2;
  localparam logic [1:0]  SEL_FULL_ON     = 2'h3;

  // Timing
  localparam int          MCLK_HZ         = 40_000_000;
  localparam int          WINDOW_MS       = 40;
  localparam int          WINDOW_CYC      = MCLK_HZ / 1000 * WINDOW_MS;
  localparam int          RESTART_US      = 1000;
  localparam int          RESTART_CYC     = MCLK_HZ / 1_000_000 * RESTART_US;
  localparam int          BASE_FREQ_HZ    = 102_400;
  localparam int          BASE_DIV_NOM    = MCLK_HZ / BASE_FREQ_HZ;
  localparam int          TRIM_STEP_CYC   = 20;
endpackage : chan_pkg

// >>> channel_protect_inrush_pwm.sv
// Eight-channel switch control: protection, pairing, inrush, PWM
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// Behaviour
// RULE_01: Eight switched channels; channels 2 to 7 are auto-configurable.
// RULE_02: Inverse current never makes a channel change state by itself.
// RULE_03: Error flag may set when on and overtemperature during inverse.
// RULE_04: No protection acts on a channel carrying inverse current. Code still switches it off when its paired partner trips.
// RULE_05: Paired channels: first one tripping also switches off its partner.
// RULE_06: Pair bits: 0 pairs 0/2, 1 pairs 1/3, 2 pairs 4/6, 3 pairs 5/7.
// RULE_07: Pair bits couple shutdown only, never normal on/off switching.
// RULE_08: Host switches each channel of a pair with its own command.
// RULE_09: Overload on a channel latches it off.
// RULE_10: Without inrush mode, latch holds until host writes latch clear.
// RULE_11: With inrush enabled, a trip restarts after the restart time.
// RULE_12: Restart counter starts counting when the channel switches on.
// RULE_13: Every switch-off, from any source, clears the inrush enable bit. Code clears it only when cmd falls, not on a protection blank.
// RULE_14: With inrush enabled, errors still flag but do not latch off.
// RULE_15: Inrush enable clears itself 40 ms after being set.
// RULE_16: Inrush mode is chosen per channel, independently.
// RULE_17: Two independent PWM generators, each mappable to any channels.
// RULE_18: Both generators use one base tick, trimmed by a 4-bit field.
// RULE_19: New 8-bit duty takes effect only at period end.
// RULE_20: Divider select 1024/512/256, last code forces full on.
// RULE_21: Restart and window delays are counters with parameter limits.
module channel_protect_inrush_pwm #(
  parameter logic [chan_pkg::CNT_W-1:0] WINDOW_LIMIT  =
    chan_pkg::CNT_W'(chan_pkg::WINDOW_CYC),
  parameter logic [chan_pkg::CNT_W-1:0] RESTART_LIMIT =
    chan_pkg::CNT_W'(chan_pkg::RESTART_CYC)
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // Register port
  input  wire logic [chan_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [chan_pkg::DATA_W-1:0]   regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [chan_pkg::DATA_W-1:0]   regRdata,
  // Analog sense comparators, asynchronous
  input  wire logic [chan_pkg::NUM_CH-1:0]   overloadIn,
  input  wire logic [chan_pkg::NUM_CH-1:0]   overtempIn,
  input  wire logic [chan_pkg::NUM_CH-1:0]   inverseIn,
  // Gate drive
  output logic      [chan_pkg::NUM_CH-1:0]   gateOn
);
  import chan_pkg::*;

  // Partner index of a pairable channel
  function automatic int partnerOf(input int ch);
    partnerOf = ch ^ 2;
  endfunction : partnerOf

  // Pair control bit governing a channel
  function automatic int pairBitOf(input int ch);
    pairBitOf = ((ch >> 2) << 1) | (ch & 1);
  endfunction : pairBitOf

  // Two-stage synchronisers for the sense inputs
  logic [NUM_CH-1:0] ovlS1_r, ovlS2_r, otpS1_r, otpS2_r, invS1_r, invS2_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovlS1_r <= 8'h00;
      ovlS2_r <= 8'h00;
      otpS1_r <= 8'h00;
      otpS2_r <= 8'h00;
      invS1_r <= 8'h00;
      invS2_r <= 8'h00;
    end else begin
      ovlS1_r <= overloadIn;
      ovlS2_r <= ovlS1_r;
      otpS1_r <= overtempIn;
      otpS2_r <= otpS1_r;
      invS1_r <= inverseIn;
      invS2_r <= invS1_r;
    end
  end

  // Software-visible configuration
  logic [NUM_CH-1:0]   swOn_r,   swOn_nxt;
  logic [NUM_PAIR-1:0] pair_r,   pair_nxt;
  logic [3:0]          trim_r,   trim_nxt;
  logic [7:0]          duty0_r,  duty0_nxt, duty1_r, duty1_nxt;
  logic [1:0]          sel0_r,   sel0_nxt,  sel1_r,  sel1_nxt;
  logic [NUM_CH-1:0]   map0_r,   map0_nxt,  map1_r,  map1_nxt;
  logic [DATA_W-1:0]   rdata_r,  rdata_nxt;
  logic                wrSw, wrPair, wrOcl, wrInr, wrErr, wrTrim;
  logic                wrPwm0, wrPwm1, wrMap;

  // Protection state
  logic [NUM_CH-1:0] latch_r,  latch_nxt;
  logic [NUM_CH-1:0] blank_r,  blank_nxt;
  logic [NUM_CH-1:0] inrush_r, inrush_nxt;
  logic [NUM_CH-1:0] err_r,    err_nxt;
  logic [NUM_CH-1:0] on_r,     on_nxt;
  logic [NUM_CH-1:0] cmd_r,    cmd_nxt;
  logic [CNT_W-1:0]  winCnt_r [NUM_CH];
  logic [CNT_W-1:0]  winCnt_nxt [NUM_CH];
  logic [CNT_W-1:0]  rstCnt_r [NUM_CH];
  logic [CNT_W-1:0]  rstCnt_nxt [NUM_CH];

  // Base tick
  logic [9:0]        tickCnt_r, tickCnt_nxt;
  logic              tick_r,    tick_nxt;
  logic [9:0]        reload;
  logic              pwm0, pwm1;
  logic [NUM_CH-1:0] trip, cmd;

  // Address decode, write side
  always_comb begin
    wrSw   = regWr && (regAddr == OFS_SWITCH);
    wrPair = regWr && (regAddr == OFS_PAIR);
    wrOcl  = regWr && (regAddr == OFS_OCL);
    wrInr  = regWr && (regAddr == OFS_INRUSH);
    wrErr  = regWr && (regAddr == OFS_ERR);
    wrTrim = regWr && (regAddr == OFS_TRIM);
    wrPwm0 = regWr && (regAddr == OFS_PWM0);
    wrPwm1 = regWr && (regAddr == OFS_PWM1);
    wrMap  = regWr && (regAddr == OFS_MAP);
  end

  // Configuration registers and read data
  always_comb begin
    swOn_nxt  = wrSw   ? regWdata[NUM_CH-1:0]   : swOn_r;
    pair_nxt  = wrPair ? regWdata[NUM_PAIR-1:0] : pair_r; // see RULE_06
    trim_nxt  = wrTrim ? regWdata[3:0]          : trim_r; // see RULE_18
    duty0_nxt = wrPwm0 ? regWdata[PWM_DUTY_LSB +: 8] : duty0_r;
    sel0_nxt  = wrPwm0 ? regWdata[PWM_SEL_LSB +: 2]  : sel0_r;
    duty1_nxt = wrPwm1 ? regWdata[PWM_DUTY_LSB +: 8] : duty1_r;
    sel1_nxt  = wrPwm1 ? regWdata[PWM_SEL_LSB +: 2]  : sel1_r;
    map0_nxt  = wrMap  ? regWdata[NUM_CH-1:0]        : map0_r; // see RULE_17
    map1_nxt  = wrMap  ? regWdata[MAP1_LSB +: NUM_CH] : map1_r;
    rdata_nxt = '0;
    if (regRd) begin
      case (regAddr)
        OFS_SWITCH: rdata_nxt[NUM_CH-1:0]   = swOn_r;
        OFS_PAIR:   rdata_nxt[NUM_PAIR-1:0] = pair_r;
        OFS_INRUSH: rdata_nxt[NUM_CH-1:0]   = inrush_r;
        OFS_ERR:    rdata_nxt[NUM_CH-1:0]   = err_r;
        OFS_TRIM:   rdata_nxt[3:0]          = trim_r;
        OFS_PWM0:   rdata_nxt[9:0]          = {sel0_r, duty0_r};
        OFS_PWM1:   rdata_nxt[9:0]          = {sel1_r, duty1_r};
        OFS_MAP:    rdata_nxt[15:0]         = {map1_r, map0_r};
        OFS_STATUS: begin
          rdata_nxt[NUM_CH-1:0]                = on_r;
          rdata_nxt[STAT_LATCH_LSB +: NUM_CH]  = latch_r;
          rdata_nxt[STAT_AUTO_LSB +: NUM_CH]   = AUTOCFG_MASK; // see RULE_01
        end
        default:    rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      swOn_r  <= 8'h00;
      pair_r  <= 4'h0;
      trim_r  <= TRIM_RESET;
      duty0_r <= DUTY_RESET;
      sel0_r  <= SEL_RESET;
      duty1_r <= DUTY_RESET;
      sel1_r  <= SEL_RESET;
      map0_r  <= 8'h00;
      map1_r  <= 8'h00;
      rdata_r <= '0;
    end else begin
      swOn_r  <= swOn_nxt;
      pair_r  <= pair_nxt;
      trim_r  <= trim_nxt;
      duty0_r <= duty0_nxt;
      sel0_r  <= sel0_nxt;
      duty1_r <= duty1_nxt;
      sel1_r  <= sel1_nxt;
      map0_r  <= map0_nxt;
      map1_r  <= map1_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Base tick; reserved trim code 0 falls back to nominal
  always_comb begin
    int adj;
    adj = (trim_r == 4'h0) ? 0 : int'(trim_r) - int'(TRIM_RESET);
    reload = 10'(BASE_DIV_NOM - adj * TRIM_STEP_CYC - 1); // see RULE_18
    tick_nxt    = (tickCnt_r == 10'h000);
    tickCnt_nxt = (tickCnt_r == 10'h000) ? reload : tickCnt_r - 10'h001;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tickCnt_r <= 10'h000;
      tick_r    <= 1'b0;
    end else begin
      tickCnt_r <= tickCnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

  // Two generators sharing one tick
  pwm_gen u_pwm0 (
    .mclk   (mclk),
    .rst    (rst),
    .tick   (tick_r),
    .duty   (duty0_r),
    .divSel (sel0_r),
    .pwmOut (pwm0)
  ); // see RULE_17

  pwm_gen u_pwm1 (
    .mclk   (mclk),
    .rst    (rst),
    .tick   (tick_r),
    .duty   (duty1_r),
    .divSel (sel1_r),
    .pwmOut (pwm1)
  );

  // Channel command and trip detection
  always_comb begin
    // Each channel has its own command; pairing never merges them
    cmd = swOn_r | (map0_r & {NUM_CH{pwm0}})
        | (map1_r & {NUM_CH{pwm1}}); // see RULE_07, RULE_08
    // Inverse current masks the channel's own overload and overtemperature trip, not a partner's
    trip = on_r & (ovlS2_r | otpS2_r) & ~invS2_r; // see RULE_04, RULE_09
  end

  // Per-channel protection, inrush and error state
  always_comb begin
    latch_nxt  = latch_r;
    blank_nxt  = blank_r;
    inrush_nxt = inrush_r;
    err_nxt    = err_r;
    cmd_nxt    = cmd;
    for (int i = 0; i < NUM_CH; i++) begin
      logic hit;
      hit = trip[i];
      if (i != 2 && i != 3 && i != 6 && i != 7) begin
        if (pair_r[pairBitOf(i)] && trip[partnerOf(i)])
          hit = 1'b1; // see RULE_05
      end else begin
        if (pair_r[pairBitOf(i)] && trip[partnerOf(i)])
          hit = 1'b1; // see RULE_05
      end
      winCnt_nxt[i] = winCnt_r[i];
      rstCnt_nxt[i] = rstCnt_r[i];
      // Errors flag even during inverse when the channel is hot and on
      if (wrErr && regWdata[i])
        err_nxt[i] = 1'b0;
      if (on_r[i] && (otpS2_r[i] || (ovlS2_r[i] && !invS2_r[i])))
        err_nxt[i] = 1'b1; // see RULE_03, RULE_14
      if (wrOcl && regWdata[i])
        latch_nxt[i] = 1'b0; // see RULE_10
      if (hit && !inrush_r[i])
        latch_nxt[i] = 1'b1; // see RULE_09
      // Inrush: trip only blanks, restart counter runs from switch-on
      if (hit && inrush_r[i])
        blank_nxt[i] = 1'b1; // see RULE_11, RULE_14
      if (cmd[i] && !cmd_r[i]) begin
        rstCnt_nxt[i] = '0; // see RULE_12
      end else if (cmd[i]) begin
        if (rstCnt_r[i] >= RESTART_LIMIT - 1'b1) begin
          rstCnt_nxt[i] = '0;
          blank_nxt[i]  = 1'b0; // see RULE_11, RULE_21
        end else begin
          rstCnt_nxt[i] = rstCnt_r[i] + 1'b1;
        end
      end
      // Window timer limits how long inrush stays armed
      if (inrush_r[i]) begin
        if (winCnt_r[i] >= WINDOW_LIMIT - 1'b1) begin
          inrush_nxt[i] = 1'b0; // see RULE_15, RULE_21
          winCnt_nxt[i] = '0;
        end else begin
          winCnt_nxt[i] = winCnt_r[i] + 1'b1;
        end
      end
      if (!cmd[i] && cmd_r[i]) begin
        inrush_nxt[i] = 1'b0; // see RULE_13
        blank_nxt[i]  = 1'b0;
      end
      if (!inrush_nxt[i])
        blank_nxt[i] = 1'b0;
      // Software arming is per channel and restarts the window
      if (wrInr) begin
        inrush_nxt[i] = regWdata[i]; // see RULE_16
        winCnt_nxt[i] = '0;
      end
    end
    // State only moves on command or protection, never on inverse alone
    on_nxt = cmd & ~latch_nxt & ~blank_nxt; // see RULE_02
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latch_r  <= 8'h00;
      blank_r  <= 8'h00;
      inrush_r <= 8'h00;
      err_r    <= 8'h00;
      on_r     <= 8'h00;
      cmd_r    <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
        winCnt_r[i] <= '0;
        rstCnt_r[i] <= '0;
      end
    end else begin
      latch_r  <= latch_nxt;
      blank_r  <= blank_nxt;
      inrush_r <= inrush_nxt;
      err_r    <= err_nxt;
      on_r     <= on_nxt;
      cmd_r    <= cmd_nxt;
      for (int i = 0; i < NUM_CH; i++) begin
        winCnt_r[i] <= winCnt_nxt[i];
        rstCnt_r[i] <= rstCnt_nxt[i];
      end
    end
  end

  assign regRdata = rdata_r;
  assign gateOn   = on_r;
endmodule : channel_protect_inrush_pwm

// >>> channel_protect_inrush_pwm_assertions.sv
// Port-level checks for the channel switch block
`timescale 1ns/1ps
module channel_protect_inrush_pwm_chk (
  // Clock and reset
  input wire logic                        mclk,
  input wire logic                        rst,
  // Register port
  input wire logic [chan_pkg::ADDR_W-1:0] regAddr,
  input wire logic [chan_pkg::DATA_W-1:0] regWdata,
  input wire logic                        regWr,
  input wire logic                        regRd,
  input wire logic [chan_pkg::DATA_W-1:0] regRdata,
  // Sense and drive
  input wire logic [chan_pkg::NUM_CH-1:0] overloadIn,
  input wire logic [chan_pkg::NUM_CH-1:0] overtempIn,
  input wire logic [chan_pkg::NUM_CH-1:0] inverseIn,
  input wire logic [chan_pkg::NUM_CH-1:0] gateOn
);
  import chan_pkg::*;
  logic [3:0]  pairCopy_r;
  logic [3:0]  pairCopy_nxt;
  logic [15:0] mapCopy_r;
  logic [15:0] mapCopy_nxt;
  logic [7:0]  pwmCh;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Shadow pairing and mapping, needed to excuse PWM-driven edges
  always_comb begin
    pairCopy_nxt = pairCopy_r;
    mapCopy_nxt = mapCopy_r;
    if (regWr && regAddr == OFS_PAIR) pairCopy_nxt = regWdata[3:0];
    if (regWr && regAddr == OFS_MAP) mapCopy_nxt = regWdata[15:0];
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pairCopy_r <= '0;
      mapCopy_r <= '0;
    end else begin
      pairCopy_r <= pairCopy_nxt;
      mapCopy_r <= mapCopy_nxt;
    end
  end
  assign pwmCh = mapCopy_r[7:0] | mapCopy_r[15:8];
  // Protection trips every channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_trip
    a_trip_off:
      assert property ($rose(overloadIn[c]) && gateOn[c] && !inverseIn[c]
        |-> ##[1:5] !gateOn[c]) else $error("gate on after overload");
  end
  a_pair_off:
    assert property (pairCopy_r[0] && $rose(overloadIn[0] | overtempIn[0])
      && gateOn[0] && gateOn[2] && !inverseIn[0] |-> ##[1:5] !gateOn[2])
      else $error("partner stayed on");
  a_pair_decoupled:
    assert property (pairCopy_r[0] && regWr && regAddr == OFS_SWITCH &&
      !regWdata[2] && !gateOn[2] && !pwmCh[2] |=> !gateOn[2] [*2])
      else $error("partner switched with neighbour");
  a_inverse_hold:
    assert property ($fell(gateOn[0]) && inverseIn[0] &&
      $past(inverseIn[0], 6) |-> $past(regWr) || $past(regWr, 2) || pwmCh[0])
      else $error("gate fell by itself under inverse current");
  a_status_read:
    assert property (regRd && regAddr == OFS_STATUS |=>
      regRdata[7:0] == $past(gateOn) &&
      regRdata[31:16] == {8'h00, AUTOCFG_MASK})
      else $error("status word wrong");
  a_read_window:
    assert property (regRdata != '0 |-> $past(regRd))
      else $error("read data outside its cycle");
  a_unmapped_zero:
    assert property (regRd && regAddr > OFS_STATUS |=> regRdata == '0)
      else $error("unmapped read not zero");
  a_ocl_reads0:
    assert property (regRd && regAddr == OFS_OCL |=> regRdata == '0)
      else $error("latch clear reads nonzero");
  a_reset_quiet:
    assert property (disable iff (1'b0) rst |-> gateOn == '0 && regRdata == '0)
      else $error("outputs active in reset");
  // Main scenarios
  cover property (regWr && regAddr == OFS_PAIR && regWdata[0]);
  cover property ($fell(gateOn[0]) && inverseIn[0]);
  cover property (regRd && regAddr == OFS_STATUS);
endmodule : channel_protect_inrush_pwm_chk
bind channel_protect_inrush_pwm channel_protect_inrush_pwm_chk chk (
  .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .overloadIn(overloadIn), .overtempIn(overtempIn),
  .inverseIn(inverseIn), .gateOn(gateOn));

// >>> channel_protect_inrush_pwm_tb.sv
// Self-checking bench for the channel switch block
`timescale 1ns/1ps
module channel_protect_inrush_pwm_tb;
  import chan_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
  } row_t;
  logic              mclk = 1'b0;
  logic              rst = 1'b0;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdata;
  logic [NUM_CH-1:0] overloadIn = '0;
  logic [NUM_CH-1:0] overtempIn = '0;
  logic [NUM_CH-1:0] inverseIn = '0;
  logic [NUM_CH-1:0] gateOn;
  logic [DATA_W-1:0] rdv;
  row_t              rows [9];
  int                pa [4] = '{0, 1, 4, 5};
  int                err_count = 0;
  int                n_compared = 0;
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  host_bus host (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  // Short windows keep the run brief
  channel_protect_inrush_pwm #(.WINDOW_LIMIT(21'd200),
    .RESTART_LIMIT(21'd20)) uut (.mclk(mclk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .overloadIn(overloadIn), .overtempIn(overtempIn),
    .inverseIn(inverseIn), .gateOn(gateOn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkg(input logic [7:0] exp);
    chk({24'h0, gateOn}, {24'h0, exp});
  endtask : chkg
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Bounded wait for one gate to come back on
  task automatic waitg(input int c, input int lim);
    int i;
    i = 0;
    while (gateOn[c] !== 1'b1 && i < lim) begin
      @(posedge mclk);
      i++;
    end
    chk({31'h0, gateOn[c]}, 32'h1);
    // A gate that never returns ends the run at once
    if (gateOn[c] !== 1'b1) report_and_stop();
  endtask : waitg
  task automatic report_and_stop;
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Hang guard
  initial begin
    tick(100000);
    err_count++;
    report_and_stop();
  end
  initial begin
    rows[0] = '{OFS_PAIR, 32'h3f, 32'h0f};
    rows[1] = '{OFS_TRIM, 32'hf5, 32'h05};
    rows[2] = '{OFS_PWM0, 32'h3ff, 32'h3ff};
    rows[3] = '{OFS_PWM1, 32'h155, 32'h155};
    rows[4] = '{OFS_MAP, 32'h10201, 32'h0201};
    rows[5] = '{OFS_OCL, 32'hff, 32'h0};
    rows[6] = '{8'h28, 32'hffffffff, 32'h0};
    rows[7] = '{OFS_MAP, 32'h0, 32'h0};
    rows[8] = '{OFS_PAIR, 32'h0, 32'h0};
    // Reset raised as an edge so the async branch runs before the first clock
    rst <= 1'b1;
    tick(10);
    rst <= 1'b0;
    host.rd(OFS_STATUS, rdv);
    chk(rdv, 32'h00fc0000);
    host.rd(OFS_TRIM, rdv);
    chk(rdv, {28'h0, TRIM_RESET});
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      host.rd(rows[i].a, rdv);
      chk(rdv, rows[i].e);
    end
    // Overload latch holds until cleared by the host
    host.wr(OFS_SWITCH, 32'h01);
    tick(3);
    chkg(8'h01);
    overloadIn[0] <= 1'b1;
    tick(6);
    chkg(8'h00);
    overloadIn[0] <= 1'b0;
    tick(6);
    chkg(8'h00);
    host.rd(OFS_STATUS, rdv);
    chk(rdv, 32'h00fc0100);
    host.wr(OFS_OCL, 32'h01);
    tick(3);
    chkg(8'h01);
    host.wr(OFS_SWITCH, 32'h0);
    // Each pair: single switch stays alone, one trip kills both
    for (int k = 0; k < 4; k++) begin
      host.wr(OFS_PAIR, 32'(1 << k));
      host.wr(OFS_SWITCH, 32'(1 << pa[k]));
      tick(3);
      chkg(8'(1 << pa[k]));
      host.wr(OFS_SWITCH, 32'(5 << pa[k]));
      tick(3);
      chkg(8'(5 << pa[k]));
      overtempIn[pa[k]] <= 1'b1;
      tick(6);
      chkg(8'h00);
      overtempIn[pa[k]] <= 1'b0;
      host.wr(OFS_SWITCH, 32'h0);
      host.wr(OFS_OCL, 32'hff);
    end
    host.wr(OFS_PAIR, 32'h0);
    // Inverse current masks protection on its own channel only
    host.wr(OFS_ERR, 32'hff);
    host.wr(OFS_SWITCH, 32'h03);
    inverseIn[0] <= 1'b1;
    tick(4);
    overloadIn <= 8'h03;
    overtempIn[0] <= 1'b1;
    tick(8);
    chkg(8'h01);
    host.rd(OFS_ERR, rdv);
    chk(rdv, 32'h03);
    host.wr(OFS_SWITCH, 32'h0);
    tick(3);
    chkg(8'h00);
    overloadIn <= 8'h0;
    overtempIn <= 8'h0;
    inverseIn <= 8'h0;
    tick(4);
    host.wr(OFS_OCL, 32'hff);
    // Inrush on channel 4 restarts; channel 5 latches
    host.wr(OFS_INRUSH, 32'h10);
    host.rd(OFS_INRUSH, rdv);
    chk(rdv, 32'h10);
    host.wr(OFS_SWITCH, 32'h30);
    tick(2);
    overloadIn <= 8'h30;
    tick(6);
    chkg(8'h00);
    overloadIn <= 8'h00;
    waitg(4, 60);
    chkg(8'h10);
    host.rd(OFS_STATUS, rdv);
    chk(rdv, 32'h00fc2010);
    tick(200);
    host.rd(OFS_INRUSH, rdv);
    chk(rdv, 32'h0);
    // A host switch-off drops the inrush bit
    host.wr(OFS_SWITCH, 32'h40);
    host.wr(OFS_INRUSH, 32'h40);
    host.wr(OFS_SWITCH, 32'h0);
    host.rd(OFS_INRUSH, rdv);
    chk(rdv, 32'h0);
    // Duty written mid-period must not act before period end
    host.wr(OFS_PWM0, 32'h0ff);
    host.wr(OFS_MAP, 32'h80);
    tick(500);
    chkg(8'h00);
    // Mid-run reset with a gate on: all off, defaults back
    host.wr(OFS_SWITCH, 32'h01);
    tick(3);
    rst <= 1'b1;
    tick(2);
    chkg(8'h00);
    rst <= 1'b0;
    host.rd(OFS_STATUS, rdv);
    chk(rdv, 32'h00fc0000);
    host.rd(OFS_TRIM, rdv);
    chk(rdv, {28'h0, TRIM_RESET});
    report_and_stop();
  end
endmodule : channel_protect_inrush_pwm_tb

// >>> host_bus.sv
// Host register bus master model
`timescale 1ns/1ps
module host_bus (
  // Clock
  input  wire logic                        mclk,
  // Register port
  output logic      [chan_pkg::ADDR_W-1:0] regAddr,
  output logic      [chan_pkg::DATA_W-1:0] regWdata,
  output logic                             regWr,
  output logic                             regRd,
  input  wire logic [chan_pkg::DATA_W-1:0] regRdata
);
  import chan_pkg::*;
  // Idle bus at time zero
  initial begin
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // One-cycle write; data scrambled after so stale values never match
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    regWdata <= ~d;
  endtask : wr
  // Read strobe, data taken at the edge closing the answer cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    regAddr <= ~a;
    @(posedge mclk);
    d = regRdata;
  endtask : rd
endmodule : host_bus

// >>> pwm_gen.sv
// One PWM generator stepping on the shared base-frequency tick
`timescale 1ns/1ps
module pwm_gen (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Base tick and settings
  input  wire logic       tick,
  input  wire logic [7:0] duty,
  input  wire logic [1:0] divSel,
  // Output
  output logic            pwmOut
);
  import chan_pkg::*;

  logic [9:0] phase_r,  phase_nxt;
  logic [7:0] duty_r,   duty_nxt;
  logic [1:0] sel_r,    sel_nxt;
  logic       out_r,    out_nxt;
  logic [9:0] lastPh;
  logic [7:0] pos;

  // Period length and compare position per divider
  always_comb begin
    lastPh    = 10'h3ff;
    pos       = phase_r[9:2];
    case (sel_r)
      SEL_DIV1024: begin
        lastPh = 10'h3ff;
        pos    = phase_r[9:2];
      end
      SEL_DIV512: begin
        lastPh = 10'h1ff;
        pos    = phase_r[8:1];
      end
      SEL_DIV256: begin
        lastPh = 10'h0ff;
        pos    = phase_r[7:0];
      end
      default: begin
        lastPh = 10'h0ff;
        pos    = phase_r[7:0];
      end
    endcase
  end

  // Settings are only taken at period end, so a cycle is never cut short
  always_comb begin
    phase_nxt = phase_r;
    duty_nxt  = duty_r;
    sel_nxt   = sel_r;
    if (tick) begin
      if (phase_r >= lastPh) begin
        phase_nxt = 10'h000;
        duty_nxt  = duty;   // see RULE_19
        sel_nxt   = divSel; // see RULE_20
      end else begin
        phase_nxt = phase_r + 10'h001;
      end
    end
    out_nxt = (sel_r == SEL_FULL_ON) ? 1'b1 : (pos < duty_r); // see RULE_20
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r <= 10'h000;
      duty_r  <= DUTY_RESET;
      sel_r   <= SEL_RESET;
      out_r   <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      duty_r  <= duty_nxt;
      sel_r   <= sel_nxt;
      out_r   <= out_nxt;
    end
  end

  assign pwmOut = out_r;
endmodule : pwm_gen
